/* File: hw/sbsp_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
module sbsp_fifo #(
  parameter int W = 8,
  parameter int DEPTH = sbsp_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  import sbsp_pkg::*;

  localparam int PW = $clog2(DEPTH);

  logic [W-1:0] mem_ff [DEPTH];
  logic [W-1:0] nxt_mem [DEPTH];
  logic [PW:0] wr_ptr_ff;
  logic [PW:0] nxt_wr_ptr;
  logic [PW:0] rd_ptr_ff;
  logic [PW:0] nxt_rd_ptr;
  logic full;
  logic empty;

  // extra pointer bit tells full from empty; depth must be a power of two
  assign empty = wr_ptr_ff == rd_ptr_ff;
  assign full = (wr_ptr_ff ^ rd_ptr_ff) == {1'b1, {PW{1'b0}}};
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = mem_ff[rd_ptr_ff[PW-1:0]];

  always_comb
  begin
    nxt_mem = mem_ff;
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    if (in_valid && !full)
    begin
      nxt_mem[wr_ptr_ff[PW-1:0]] = in_data;
      nxt_wr_ptr = wr_ptr_ff + 1'b1;
    end
    if (out_ready && !empty)
      nxt_rd_ptr = rd_ptr_ff + 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    mem_ff <= nxt_mem;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end
    else
    begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
    end
  end
endmodule

module sbsp_ctrl #(
  parameter int DW = sbsp_pkg::DW_X36,
  parameter int AW = sbsp_pkg::addr_w(DW),
  parameter int HALF = sbsp_pkg::K_HALF_CYC,
  parameter int DEPTH = sbsp_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [AW-1:0] req_addr,
  input wire logic [DW-1:0] req_data0,
  input wire logic [DW-1:0] req_data1,
  input wire logic [sbsp_pkg::BWS_W-1:0] req_mask0_n,
  input wire logic [sbsp_pkg::BWS_W-1:0] req_mask1_n,
  output logic rd_valid,
  output logic [DW-1:0] rd_data0,
  output logic [DW-1:0] rd_data1,
  sbsp_link_if.ctrl link
);
  import sbsp_pkg::*;

  localparam int FW = 1 + AW + 2 * DW + 2 * BWS_W;
  localparam int CW = $clog2(2 * HALF);
  localparam logic [CW-1:0] LAST = CW'(2 * HALF - 1);
  localparam logic [CW-1:0] LOAD_PT = CW'(HALF + HALF / 2);
  localparam logic [CW-1:0] W1_PT = CW'(HALF / 2);
  localparam logic [CW-1:0] S0_PT = CW'(HALF - 1);

  logic [FW-1:0] head;
  logic head_valid;
  logic pop;
  logic h_write;
  logic [AW-1:0] h_addr;
  logic [DW-1:0] h_d0;
  logic [DW-1:0] h_d1;
  logic [BWS_W-1:0] h_m0;
  logic [BWS_W-1:0] h_m1;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic slot_ff, nxt_slot;
  logic k_ff, nxt_k;
  logic ld_n_ff, nxt_ld_n;
  logic rnw_ff, nxt_rnw;
  logic [AW-1:0] addr_ff, nxt_addr;
  logic [DW-1:0] d_ff, nxt_d;
  logic [BWS_W-1:0] mask_ff, nxt_mask;
  logic [DW-1:0] hold_d_ff, nxt_hold_d;
  logic [BWS_W-1:0] hold_m_ff, nxt_hold_m;
  logic wr_iss_ff, nxt_wr_iss;
  logic rd_iss_ff, nxt_rd_iss;
  logic [1:0] rd_pipe_ff, nxt_rd_pipe;
  logic rd_valid_ff, nxt_rd_valid;
  logic [DW-1:0] rd0_ff, nxt_rd0;
  logic [DW-1:0] rd1_ff, nxt_rd1;
  logic [DW:0] q_sync1_ff;
  logic [DW:0] q_sync2_ff;
  logic s_q_oe;
  logic [DW-1:0] s_q;

  // requests queue here; a full queue stalls the user
  sbsp_fifo #(.W(FW), .DEPTH(DEPTH)) sbsp_fifo_inst (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data({req_write, req_addr, req_data0, req_data1, req_mask0_n, req_mask1_n}),
    .out_valid(head_valid),
    .out_ready(pop),
    .out_data(head)
  );

  assign {h_write, h_addr, h_d0, h_d1, h_m0, h_m1} = head;

  // read bus is timed by the device's clocks, so it takes two flops;
  // the sample points sit late enough in each phase to absorb them
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q_sync1_ff <= '0;
      q_sync2_ff <= '0;
    end
    else
    begin
      q_sync1_ff <= {link.q_oe, link.q};
      q_sync2_ff <= q_sync1_ff;
    end
  end

  assign {s_q_oe, s_q} = q_sync2_ff;

  // divider makes the link clock; data moves mid-phase, far from edges
  always_comb
  begin
    nxt_cnt = (cnt_ff == LAST) ? '0 : cnt_ff + 1'b1;
    nxt_k = nxt_cnt < CW'(HALF);
    nxt_slot = slot_ff;
    nxt_ld_n = ld_n_ff;
    nxt_rnw = rnw_ff;
    nxt_addr = addr_ff;
    nxt_d = d_ff;
    nxt_mask = mask_ff;
    nxt_hold_d = hold_d_ff;
    nxt_hold_m = hold_m_ff;
    nxt_wr_iss = wr_iss_ff;
    nxt_rd_iss = rd_iss_ff;
    nxt_rd_pipe = rd_pipe_ff;
    nxt_rd_valid = 1'b0;
    nxt_rd0 = rd0_ff;
    nxt_rd1 = rd1_ff;
    pop = 1'b0;
    if (cnt_ff == LAST)
    begin
      nxt_slot = ~slot_ff;
      nxt_rd_pipe = {rd_pipe_ff[0], rd_iss_ff};
    end
    if (cnt_ff == LOAD_PT)
    begin
      nxt_ld_n = 1'b1;
      nxt_d = '0;
      nxt_mask = '1;
      nxt_wr_iss = 1'b0;
      nxt_rd_iss = 1'b0;
      // writes only in odd-to-even slots, reads in the others; a head of
      // the wrong kind waits one period
      if (head_valid && (h_write == slot_ff))
      begin
        pop = 1'b1;
        nxt_ld_n = 1'b0;
        nxt_rnw = ~h_write;
        nxt_addr = h_addr;
        nxt_d = h_d0;
        nxt_mask = h_m0;
        nxt_hold_d = h_d1;
        nxt_hold_m = h_m1;
        nxt_wr_iss = h_write;
        nxt_rd_iss = ~h_write;
      end
    end
    if (cnt_ff == W1_PT && wr_iss_ff)
    begin
      nxt_d = hold_d_ff;
      nxt_mask = hold_m_ff;
    end
    // read words come back one period after the load
    if (rd_pipe_ff[1] && s_q_oe && cnt_ff == S0_PT)
      nxt_rd0 = s_q;
    if (rd_pipe_ff[1] && cnt_ff == LAST)
    begin
      nxt_rd1 = s_q;
      nxt_rd_valid = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff <= '0;
      slot_ff <= 1'b0;
      k_ff <= RST_CLK;
      ld_n_ff <= RST_STROBE_N;
      rnw_ff <= 1'b1;
      addr_ff <= '0;
      d_ff <= '0;
      mask_ff <= '1;
      hold_d_ff <= '0;
      hold_m_ff <= '1;
      wr_iss_ff <= 1'b0;
      rd_iss_ff <= 1'b0;
      rd_pipe_ff <= '0;
      rd_valid_ff <= 1'b0;
      rd0_ff <= '0;
      rd1_ff <= '0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      slot_ff <= nxt_slot;
      k_ff <= nxt_k;
      ld_n_ff <= nxt_ld_n;
      rnw_ff <= nxt_rnw;
      addr_ff <= nxt_addr;
      d_ff <= nxt_d;
      mask_ff <= nxt_mask;
      hold_d_ff <= nxt_hold_d;
      hold_m_ff <= nxt_hold_m;
      wr_iss_ff <= nxt_wr_iss;
      rd_iss_ff <= nxt_rd_iss;
      rd_pipe_ff <= nxt_rd_pipe;
      rd_valid_ff <= nxt_rd_valid;
      rd0_ff <= nxt_rd0;
      rd1_ff <= nxt_rd1;
    end
  end

  // output clocks mirror the input clocks; the device may ignore them
  assign link.k = k_ff;
  assign link.k_n = ~k_ff;
  assign link.c = k_ff;
  assign link.c_n = ~k_ff;
  assign link.load_strobe_n = ld_n_ff;
  assign link.read_not_write = rnw_ff;
  assign link.addr = addr_ff;
  assign link.d = d_ff;
  assign link.byte_write_mask_n = mask_ff;
  assign link.nibble_write_mask_n = mask_ff[NWS_W-1:0];
  assign rd_valid = rd_valid_ff;
  assign rd_data0 = rd0_ff;
  assign rd_data1 = rd1_ff;
endmodule
`default_nettype wire

/* File: hw/sbsp_pkg.sv */
package sbsp_pkg;
  // word widths of the four organisations
  localparam int DW_X8 = 8;
  localparam int DW_X9 = 9;
  localparam int DW_X18 = 18;
  localparam int DW_X36 = 36;
  // address widths per organisation
  localparam int AW_X8 = 22;
  localparam int AW_X18 = 21;
  localparam int AW_X36 = 20;
  // write mask lanes
  localparam int NIB_W = 4;
  localparam int BYTE_W = 9;
  localparam int BWS_W = 4;
  localparam int NWS_W = 2;
  // words per loaded address
  localparam int BURST_LEN = 2;
  // controller divider: sys_clk cycles per half period of the link clock
  localparam int K_HALF_CYC = 8;
  // flop-backed array depth in index bits, queue depth in entries, kept small on purpose
  localparam int MEM_IDX_W = 4;
  localparam int FIFO_DEPTH = 4;
  // reset levels
  localparam logic RST_STROBE_N = 1'b1;
  localparam logic RST_CLK = 1'b0;

  function automatic int addr_w(input int dw);
    return (dw <= DW_X9) ? AW_X8 : ((dw == DW_X18) ? AW_X18 : AW_X36);
  endfunction

  function automatic int lane_w(input int dw);
    return (dw == DW_X8) ? NIB_W : BYTE_W;
  endfunction
endpackage

/* File: hw/sbsp_link_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface sbsp_link_if #(
  parameter int DW = sbsp_pkg::DW_X36,
  parameter int AW = sbsp_pkg::addr_w(DW)
);
  logic k;
  logic k_n;
  logic c;
  logic c_n;
  logic load_strobe_n;
  logic read_not_write;
  logic [AW-1:0] addr;
  logic [DW-1:0] d;
  logic [sbsp_pkg::BWS_W-1:0] byte_write_mask_n;
  logic [sbsp_pkg::NWS_W-1:0] nibble_write_mask_n;
  logic [DW-1:0] q;
  logic q_oe;
  logic return_timing_out;
  logic return_timing_out_n;

  modport dev (
    input k, k_n, c, c_n, load_strobe_n, read_not_write, addr, d,
    input byte_write_mask_n, nibble_write_mask_n,
    output q, q_oe, return_timing_out, return_timing_out_n
  );

  modport ctrl (
    output k, k_n, c, c_n, load_strobe_n, read_not_write, addr, d,
    output byte_write_mask_n, nibble_write_mask_n,
    input q, q_oe, return_timing_out, return_timing_out_n
  );
endinterface
`default_nettype wire

/* File: hw/sbsp_dev.sv */
// Functional notes
// - write data captured on both input-clock rises
// - low load strobe defines a new transaction
// - each load moves exactly two words
// - x8 nibble masks gate upper and lower nibble
// - masks sampled with their data word
// - byte masks cover nine-bit lanes, masked kept
// - address sampled only on true clock rise
// - address width follows the organisation
// - address ignored when port not selected
// - read data launched on output or input clocks
// - read bus released when no read selected
// - direction high reads, low writes
// - every access starts on true clock rise
// - echo clocks follow input clock in single mode
`timescale 1ns/1ns
`default_nettype none
module sbsp_dev #(
  parameter int DW = sbsp_pkg::DW_X36,
  parameter int AW = sbsp_pkg::addr_w(DW),
  parameter int IDX_W = sbsp_pkg::MEM_IDX_W
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic single_clock_mode,
  sbsp_link_if.dev link
);
  import sbsp_pkg::*;

  localparam int LW = lane_w(DW);
  localparam int LANES = DW / LW;
  localparam int DEPTH = 1 << IDX_W;
  localparam int SW = 7 + AW + DW + BWS_W + NWS_W;

  logic [SW-1:0] raw;
  logic [SW-1:0] sync1_ff;
  logic [SW-1:0] sync2_ff;
  logic s_single;
  logic s_k;
  logic s_kn;
  logic s_c;
  logic s_cn;
  logic s_ld_n;
  logic s_rnw;
  logic [AW-1:0] s_addr;
  logic [DW-1:0] s_d;
  logic [BWS_W-1:0] s_bws_n;
  logic [NWS_W-1:0] s_nws_n;
  logic [3:0] clk_prev_ff;
  logic k_rise;
  logic kn_rise;
  logic out_t_rise;
  logic out_c_rise;
  logic wr_load;
  logic rd_load;
  logic [DW-1:0] wbits;
  logic [DW-1:0] mem_ff [DEPTH][BURST_LEN];
  logic [DW-1:0] nxt_mem [DEPTH][BURST_LEN];
  logic wr_second_ff;
  logic nxt_wr_second;
  logic [IDX_W-1:0] wr_idx_ff;
  logic [IDX_W-1:0] nxt_wr_idx;
  logic rd_pend_ff;
  logic nxt_rd_pend;
  logic [IDX_W-1:0] rd_idx_ff;
  logic [IDX_W-1:0] nxt_rd_idx;
  logic rd_word1_ff;
  logic nxt_rd_word1;
  logic [IDX_W-1:0] out_idx_ff;
  logic [IDX_W-1:0] nxt_out_idx;
  logic [DW-1:0] q_ff;
  logic [DW-1:0] nxt_q;
  logic q_oe_ff;
  logic nxt_q_oe;
  logic echo_ff;
  logic nxt_echo;
  logic echo_n_ff;
  logic nxt_echo_n;

  // every pin comes from another domain, so all of it takes two flops
  assign raw = {single_clock_mode, link.k, link.k_n, link.c, link.c_n,
                link.load_strobe_n, link.read_not_write, link.addr, link.d,
                link.byte_write_mask_n, link.nibble_write_mask_n};

  // one synchroniser for clocks and data alike keeps their skew equal
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end
    else
    begin
      sync1_ff <= raw;
      sync2_ff <= sync1_ff;
    end
  end

  assign {s_single, s_k, s_kn, s_c, s_cn, s_ld_n, s_rnw, s_addr, s_d,
          s_bws_n, s_nws_n} = sync2_ff;

  // edge finders read only the second stage
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      clk_prev_ff <= {RST_CLK, RST_CLK, RST_CLK, RST_CLK};
    else
      clk_prev_ff <= {s_k, s_kn, s_c, s_cn};
  end

  assign k_rise = s_k & ~clk_prev_ff[3];
  assign kn_rise = s_kn & ~clk_prev_ff[2];
  // output launch clocks: true/complement input clocks in single mode
  assign out_t_rise = s_single ? k_rise : (s_c & ~clk_prev_ff[1]);
  assign out_c_rise = s_single ? kn_rise : (s_cn & ~clk_prev_ff[0]);

  // loads decode only on a true clock rise with the strobe low
  assign wr_load = k_rise & ~s_ld_n & ~s_rnw;
  assign rd_load = k_rise & ~s_ld_n & s_rnw;

  // per-lane write enables; x8 uses nibble masks, the rest byte masks
  for (genvar g = 0; g < LANES; g++)
  begin : g_lane
    logic lane_sel;
    if (DW == DW_X8)
    begin : g_nib
      assign lane_sel = ~s_nws_n[g];
    end
    else
    begin : g_byte
      assign lane_sel = ~s_bws_n[g];
    end
    assign wbits[g*LW +: LW] = {LW{lane_sel}};
  end

  // write side: word 0 on the true rise, word 1 on the complement rise
  always_comb
  begin
    nxt_mem = mem_ff;
    nxt_wr_second = wr_second_ff;
    nxt_wr_idx = wr_idx_ff;
    if (wr_load)
    begin
      nxt_wr_idx = s_addr[IDX_W-1:0];
      nxt_mem[s_addr[IDX_W-1:0]][0] = (mem_ff[s_addr[IDX_W-1:0]][0] & ~wbits)
                                      | (s_d & wbits);
      nxt_wr_second = 1'b1;
    end
    else if (kn_rise && wr_second_ff)
    begin
      nxt_mem[wr_idx_ff][1] = (mem_ff[wr_idx_ff][1] & ~wbits)
                              | (s_d & wbits);
      nxt_wr_second = 1'b0;
    end
  end

  // the array is not reset; only its control is
  always_ff @(posedge sys_clk)
  begin
    mem_ff <= nxt_mem;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_second_ff <= 1'b0;
      wr_idx_ff <= '0;
    end
    else
    begin
      wr_second_ff <= nxt_wr_second;
      wr_idx_ff <= nxt_wr_idx;
    end
  end

  // read side: a load waits one period, then bursts out two words.
  // write and read state are apart, so loads on alternate rises overlap
  always_comb
  begin
    nxt_rd_pend = rd_pend_ff;
    nxt_rd_idx = rd_idx_ff;
    nxt_rd_word1 = rd_word1_ff;
    nxt_out_idx = out_idx_ff;
    nxt_q = q_ff;
    nxt_q_oe = q_oe_ff;
    if (out_t_rise)
    begin
      if (rd_pend_ff)
      begin
        nxt_q = mem_ff[rd_idx_ff][0];
        nxt_q_oe = 1'b1;
        nxt_rd_word1 = 1'b1;
        nxt_out_idx = rd_idx_ff;
        nxt_rd_pend = 1'b0;
      end
      else
      begin
        // nothing selected: release the bus
        nxt_q = '0;
        nxt_q_oe = 1'b0;
        nxt_rd_word1 = 1'b0;
      end
    end
    else if (out_c_rise && rd_word1_ff)
    begin
      nxt_q = mem_ff[out_idx_ff][1];
      nxt_rd_word1 = 1'b0;
    end
    // taken after the launch so a load on the same rise is not lost
    if (rd_load)
    begin
      nxt_rd_pend = 1'b1;
      nxt_rd_idx = s_addr[IDX_W-1:0];
    end
    // echo clocks run free from whichever clock launches data
    nxt_echo = s_single ? s_k : s_c;
    nxt_echo_n = s_single ? s_kn : s_cn;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_pend_ff <= 1'b0;
      rd_idx_ff <= '0;
      rd_word1_ff <= 1'b0;
      out_idx_ff <= '0;
      q_ff <= '0;
      q_oe_ff <= 1'b0;
      echo_ff <= RST_CLK;
      echo_n_ff <= RST_CLK;
    end
    else
    begin
      rd_pend_ff <= nxt_rd_pend;
      rd_idx_ff <= nxt_rd_idx;
      rd_word1_ff <= nxt_rd_word1;
      out_idx_ff <= nxt_out_idx;
      q_ff <= nxt_q;
      q_oe_ff <= nxt_q_oe;
      echo_ff <= nxt_echo;
      echo_n_ff <= nxt_echo_n;
    end
  end

  assign link.q = q_ff;
  assign link.q_oe = q_oe_ff;
  assign link.return_timing_out = echo_ff;
  assign link.return_timing_out_n = echo_n_ff;
endmodule
`default_nettype wire

/* File: testbench/sbsp_link_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module sbsp_link_properties #(
  parameter int DW = 36,
  parameter int AW = 20
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic k,
  input wire logic k_n,
  input wire logic c,
  input wire logic c_n,
  input wire logic load_strobe_n,
  input wire logic read_not_write,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] d,
  input wire logic [3:0] byte_write_mask_n,
  input wire logic [1:0] nibble_write_mask_n,
  input wire logic [DW-1:0] q,
  input wire logic q_oe,
  input wire logic return_timing_out,
  input wire logic return_timing_out_n
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // released read bus must not leak stale words
  a_q_released: assert property (!q_oe |-> q == '0)
    else $error("read bus carries data while released");
  // low phase of the link clock is a full half period
  a_k_low_half: assert property ($fell(k) |-> (!k)[*8] ##1 k)
    else $error("link clock low phase has wrong length");
  // load is set up while k is low and reaches the next k rise
  a_load_before_k: assert property ($fell(load_strobe_n) |-> !k ##[2:6] k)
    else $error("load strobe not set up ahead of a k rise");
  // address and direction settled at the edge that samples them
  a_addr_held: assert property ($rose(k) && !load_strobe_n
    |-> $stable(addr) && $stable(read_not_write))
    else $error("address or direction moved at the k rise");
  // each word and its masks stand still at their capture edge
  a_word_held: assert property (($rose(k) || $rose(k_n))
    |-> $stable(d) && $stable(byte_write_mask_n))
    else $error("write word or mask moved at its capture edge");
  // ending a load leaves every lane masked off
  a_mask_idle: assert property ($rose(load_strobe_n)
    |-> &byte_write_mask_n && &nibble_write_mask_n)
    else $error("masks not idle after the load");
  // a loaded read drives the bus one link period later
  a_read_launch: assert property ($rose(k) && !load_strobe_n && read_not_write
    |-> ##[17:21] q_oe)
    else $error("read data not launched after a read load");
  // no read loaded means the bus is let go
  a_bus_let_go: assert property ($rose(k) && (load_strobe_n || !read_not_write)
    |-> ##[17:21] !q_oe)
    else $error("read bus still driven without a read");
  // echo clock tracks the output clock
  a_echo_tracks: assert property ($rose(c) |-> ##[1:5] return_timing_out)
    else $error("echo clock did not follow");
  // complement echo tracks the complement output clock
  a_echo_n_tracks: assert property ($rose(c_n) |-> ##[1:5] return_timing_out_n)
    else $error("complement echo clock did not follow");
  cover property ($rose(q_oe));
endmodule
`default_nettype wire

/* File: testbench/sio_burst2_sram_port_test.sv */
`timescale 1ns/1ns
`default_nettype none
module sio_burst2_sram_port_test;
  import sbsp_pkg::*;
  localparam int DW = DW_X36;
  localparam int AW = addr_w(DW);
  logic sys_clk, rst_n, single_clock_mode;
  logic req_valid, req_ready, req_write, rd_valid;
  logic [AW-1:0] req_addr;
  logic [DW-1:0] req_data0, req_data1, rd_data0, rd_data1;
  logic [3:0] req_mask0_n, req_mask1_n;
  logic [DW-1:0] mdl0 [16];
  logic [DW-1:0] mdl1 [16];
  int failures = 0;
  int num_checks = 0;
  int stalls = 0;
  logic n8_valid, n8_ready, n8_write, n8_rd_valid;
  logic [AW_X8-1:0] n8_addr;
  logic [DW_X8-1:0] n8_data0, n8_data1, n8_rd0, n8_rd1;
  logic [3:0] n8_mask0_n, n8_mask1_n;

  sbsp_link_if #(.DW(DW)) link();
  sbsp_ctrl #(.DW(DW)) sbsp_ctrl_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr(req_addr), .req_data0(req_data0), .req_data1(req_data1),
    .req_mask0_n(req_mask0_n), .req_mask1_n(req_mask1_n), .rd_valid(rd_valid),
    .rd_data0(rd_data0), .rd_data1(rd_data1), .link(link.ctrl));
  sbsp_dev #(.DW(DW)) sbsp_dev_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .single_clock_mode(single_clock_mode), .link(link.dev));
  sbsp_link_properties #(.DW(DW), .AW(AW)) sbsp_link_properties_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .k(link.k), .k_n(link.k_n), .c(link.c),
    .c_n(link.c_n), .load_strobe_n(link.load_strobe_n),
    .read_not_write(link.read_not_write), .addr(link.addr), .d(link.d),
    .byte_write_mask_n(link.byte_write_mask_n),
    .nibble_write_mask_n(link.nibble_write_mask_n), .q(link.q), .q_oe(link.q_oe),
    .return_timing_out(link.return_timing_out),
    .return_timing_out_n(link.return_timing_out_n));

  // second pair in the x8 organisation, so the nibble masks get exercised
  sbsp_link_if #(.DW(DW_X8)) link8();
  sbsp_ctrl #(.DW(DW_X8)) sbsp_ctrl_x8_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .req_valid(n8_valid), .req_ready(n8_ready), .req_write(n8_write),
    .req_addr(n8_addr), .req_data0(n8_data0), .req_data1(n8_data1),
    .req_mask0_n(n8_mask0_n), .req_mask1_n(n8_mask1_n), .rd_valid(n8_rd_valid),
    .rd_data0(n8_rd0), .rd_data1(n8_rd1), .link(link8.ctrl));
  sbsp_dev #(.DW(DW_X8)) sbsp_dev_x8_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .single_clock_mode(single_clock_mode), .link(link8.dev));

  // free-running system clock
  always #5 sys_clk = ~sys_clk;

  // count refused request cycles to see the queue fill
  always @(posedge sys_clk)
  begin
    if (req_valid && !req_ready)
      stalls <= stalls + 1;
  end

  task automatic report_and_stop();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // nine-bit lanes, a low mask bit lets the new lane in
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old,
    input logic [DW-1:0] nw, input logic [3:0] m);
    logic [DW-1:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (!m[i])
        r[i*9+:9] = nw[i*9+:9];
    return r;
  endfunction

  // valid stays up on return so back-to-back requests never toggle it
  task automatic send(input logic w, input logic [3:0] a, input logic [DW-1:0] x0,
    input logic [DW-1:0] x1, input logic [3:0] k0, input logic [3:0] k1);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= AW'(a);
    req_data0 <= x0;
    req_data1 <= x1;
    req_mask0_n <= k0;
    req_mask1_n <= k1;
    do @(posedge sys_clk); while (req_ready !== 1'b1);
  endtask

  task automatic wr(input logic [3:0] a, input logic [DW-1:0] x0,
    input logic [DW-1:0] x1, input logic [3:0] k0, input logic [3:0] k1);
    mdl0[a] = merge(mdl0[a], x0, k0);
    mdl1[a] = merge(mdl1[a], x1, k1);
    send(1'b1, a, x0, x1, k0, k1);
  endtask

  // read one address and compare both words against the model
  task automatic rd(input logic [3:0] a);
    int n;
    send(1'b0, a, '0, '0, 4'hf, 4'hf);
    req_valid <= 1'b0;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end while (rd_valid !== 1'b1 && n < 600);
    check(rd_valid, 1'b1);
    check(rd_data0, mdl0[a]);
    check(rd_data1, mdl1[a]);
  endtask

  // write two addresses, then read both back
  task automatic t_words();
    wr(4'h1, 36'h123456789, 36'h0fedcba98, 4'h0, 4'h0);
    wr(4'h2, 36'h0a5a5a5a5, 36'h5a5a5a5a5, 4'h0, 4'h0);
    rd(4'h1);
    rd(4'h2);
  endtask

  // one lane per pass on word0, all but that lane on word1
  task automatic t_lanes();
    wr(4'h5, 36'h111111111, 36'h222222222, 4'h0, 4'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr(4'h5, 36'h0f0f0f0f0 + i, 36'h0c3c3c3c3 - i, 4'hf ^ (4'h1 << i),
        4'h1 << i);
      rd(4'h5);
    end
    wr(4'h5, 36'h0, 36'h0, 4'hf, 4'hf);
    rd(4'h5);
  endtask

  // burst of writes fills the queue while the link drains slowly
  task automatic t_fifo();
    int s0;
    s0 = stalls;
    for (int i = 6; i < 12; i++)
      wr(4'(i), 36'h300000000 + i, 36'h0000c0000 + i, 4'h0, 4'h0);
    check(stalls != s0, 1'b1);
    for (int i = 6; i < 12; i++)
      rd(4'(i));
  endtask

  // x8 part: word0 takes only its lower nibble, word1 only its upper one
  task automatic t_nibbles();
    int n;
    n8_valid <= 1'b1;
    n8_write <= 1'b1;
    n8_addr <= 22'h3;
    n8_data0 <= 8'h5a;
    n8_data1 <= 8'hc3;
    n8_mask0_n <= 4'h0;
    n8_mask1_n <= 4'h0;
    do @(posedge sys_clk); while (n8_ready !== 1'b1);
    n8_data0 <= 8'h00;
    n8_data1 <= 8'hff;
    n8_mask0_n <= 4'he;
    n8_mask1_n <= 4'hd;
    do @(posedge sys_clk); while (n8_ready !== 1'b1);
    n8_write <= 1'b0;
    n8_mask0_n <= 4'hf;
    n8_mask1_n <= 4'hf;
    do @(posedge sys_clk); while (n8_ready !== 1'b1);
    n8_valid <= 1'b0;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end while (n8_rd_valid !== 1'b1 && n < 600);
    check(n8_rd_valid, 1'b1);
    check(n8_rd0, 8'h50);
    check(n8_rd1, 8'hf3);
  endtask

  // reads launched from the input clocks
  task automatic t_single();
    single_clock_mode <= 1'b1;
    repeat (4) @(posedge sys_clk);
    wr(4'hc, 36'h9abcdef01, 36'h010203040, 4'h0, 4'h0);
    rd(4'hc);
    single_clock_mode <= 1'b0;
    repeat (40) @(posedge sys_clk);
    check(link.q_oe, 1'b0);
    check(link.q, 64'h0);
  endtask

  // watchdog, far beyond the expected run of a few thousand cycles
  initial
  begin
    #300000;
    failures++;
    report_and_stop();
  end

  initial
  begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    single_clock_mode = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = '0;
    req_data0 = '0;
    req_data1 = '0;
    req_mask0_n = 4'hf;
    req_mask1_n = 4'hf;
    n8_valid = 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    check($bits(link.addr), 20);
    t_words();
    t_lanes();
    t_fifo();
    t_nibbles();
    t_single();
    report_and_stop();
  end
endmodule
`default_nettype wire
